// *** ucs_pkg.sv ***
// constants for the control request decoder and statistics block
package ucs_pkg;
  // setup request types
  localparam logic [7:0] RT_STD_DEV_OUT  = 8'h00;
  localparam logic [7:0] RT_STD_EP_OUT   = 8'h02;
  localparam logic [7:0] RT_STD_DEV_IN   = 8'h80;
  localparam logic [7:0] RT_STD_IF_IN    = 8'h81;
  localparam logic [7:0] RT_STD_EP_IN    = 8'h82;
  localparam logic [7:0] RT_VENDOR_IN    = 8'hc0;
  // request codes
  localparam logic [7:0] REQ_GET_STATUS  = 8'h00;
  localparam logic [7:0] REQ_CLR_FEATURE = 8'h01;
  localparam logic [7:0] REQ_GET_DESC    = 8'h06;
  localparam logic [7:0] REQ_GET_CONFIG  = 8'h08;
  localparam logic [7:0] REQ_GET_IFACE   = 8'h0a;
  localparam logic [7:0] REQ_GET_STATS   = 8'ha2;
  // descriptor types
  localparam logic [7:0] DT_DEVICE       = 8'h01;
  localparam logic [7:0] DT_CONFIG       = 8'h02;
  localparam logic [7:0] DT_STRING       = 8'h03;
  localparam logic [7:0] DT_QUALIFIER    = 8'h06;
  localparam logic [7:0] DT_OTHER_SPEED  = 8'h07;
  // feature selectors
  localparam logic [7:0] FS_EP_HALT      = 8'h00;
  localparam logic [7:0] FS_REMOTE_WAKE  = 8'h01;
  // endpoint addresses used by endpoint status, and the top endpoint number for halt clear
  localparam logic [7:0] EP_BULK_IN      = 8'h81;
  localparam logic [7:0] EP_BULK_OUT     = 8'h02;
  localparam logic [7:0] EP_NUM_MAX      = 8'h03;
  // lengths, and the tx statistics selector
  localparam logic [15:0] LEN_ZERO       = 16'h0000;
  localparam logic [15:0] LEN_ONE        = 16'h0001;
  localparam logic [15:0] LEN_TWO        = 16'h0002;
  localparam logic [15:0] LEN_RX_STATS   = 16'h0020;
  localparam logic [15:0] LEN_TX_STATS   = 16'h0028;
  localparam logic [15:0] SEL_TX_STATS   = 16'h0001;
  // frame length limit for runts
  localparam logic [13:0] RUNT_LEN       = 14'h0040;
  // counter counts and widths
  localparam int          NUM_RX         = 8;
  localparam int          NUM_TX         = 10;
  localparam int          NUM_CNT        = 18;
  localparam int          CNT_W          = 32;
  localparam int          SHORT_W        = 20;
  // counter indices, rx block then tx block
  localparam int RX_GOOD = 0, RX_CRC = 1, RX_RUNT = 2, RX_ALIGN = 3;
  localparam int RX_LONG = 4, RX_LATE = 5, RX_BAD = 6, RX_DROP = 7;
  localparam int TX_GOOD = 8, TX_PAUSE = 9, TX_SINGLE = 10, TX_MULTI = 11;
  localparam int TX_EXCOL = 12, TX_LATE = 13, TX_UNDER = 14, TX_DEFER = 15;
  localparam int TX_CARR = 16, TX_BAD = 17;
  // per-counter width: 20-bit counters hold a one here
  localparam logic [NUM_CNT-1:0] SHORT_MASK = 18'h23622;
  // data stage states, gray from idle through send to done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEND = 2'b01,
    ST_DONE = 2'b11
  } ucs_state_e;
endpackage

// *** ucs_ctrl.sv ***
// control request decoder and ethernet statistics counters
// Notes on behaviour
// - newer variant snapshots counters on read; they wrap, never clear
// - 32-bit good rx count includes frames the buffer controller drops
// - crc flag without dribble: crc error; with dribble: alignment error
// - runt error: frame under 64 bytes that also has a crc error
// - frames longer than programmed maximum counted as too long
// - 20-bit count of rx frames with a late collision
// - total errored rx frames, excluding frames dropped for lack of room
// - dropped frames bump the dropped counter, plus the good count if error free; no error counter
// - 32-bit good tx count excludes pause; pause frames in own 20-bit count
// - tx frames with one collision, and with several, counted apart
// - aborts counted per cause: excess collision, late, underrun, deferral
// - tx frames with carrier lost or absent are counted
// - 20-bit total of errored tx frames
// - set descriptor and synch frame are not supported
// - clear feature code 01h, zero length; type 00h wakeup, 02h halt
// - endpoint feature requests take endpoint 0 to 3 from index
// - get configuration returns the configuration value in one byte
// - get descriptor serves device, config, string, qualifier, other speed
// - interface and endpoint descriptor requests are stalled
// - get interface returns one byte of alternate setting
// - device status: bit0 self powered, bit1 remote wakeup, rest zero
// - endpoint status for 81h or 02h: halt in bit0, rest zero
// - host reads statistics only through the vendor statistics request
// - older variant saturates counters and clears them on read
`timescale 1ns/1ps
module ucs_ctrl (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // variant select: high for the wrapping snapshot behaviour
  input  wire logic        wrap_mode_i,
  // setup stage from the usb device core
  input  wire logic        setup_valid_i,
  input  wire logic [7:0]  req_type_i,
  input  wire logic [7:0]  req_code_i,
  input  wire logic [15:0] req_value_i,
  input  wire logic [15:0] req_index_i,
  input  wire logic [15:0] req_length_i,
  // data stage byte stream toward the host
  input  wire logic        in_ready_i,
  output logic             in_valid_o,
  output logic [7:0]       in_data_o,
  output logic             in_last_o,
  // handshake answers
  output logic             stall_o,
  output logic             ack_o,
  // descriptor service hand-off
  output logic             desc_req_o,
  output logic [7:0]       desc_type_o,
  output logic [7:0]       desc_index_o,
  // device state kept elsewhere
  input  wire logic [7:0]  config_value_i,
  input  wire logic [7:0]  alt_setting_i,
  input  wire logic        self_powered_i,
  input  wire logic        remote_wake_i,
  input  wire logic [3:0]  ep_halt_i,
  // feature clear strobes
  output logic             clr_remote_wake_o,
  output logic             clr_ep_halt_o,
  output logic [1:0]       clr_ep_num_o,
  // rx frame status, one pulse per frame
  input  wire logic        rx_done_i,
  input  wire logic        rx_crc_err_i,
  input  wire logic        rx_dribble_i,
  input  wire logic [13:0] rx_length_i,
  input  wire logic [13:0] rx_max_len_i,
  input  wire logic        rx_late_col_i,
  input  wire logic        rx_other_err_i,
  input  wire logic        rx_dropped_i,
  // tx frame status, one pulse per frame
  input  wire logic        tx_done_i,
  input  wire logic        tx_pause_i,
  input  wire logic [3:0]  tx_col_count_i,
  input  wire logic        tx_excess_col_i,
  input  wire logic        tx_late_col_i,
  input  wire logic        tx_underrun_i,
  input  wire logic        tx_excess_defer_i,
  input  wire logic        tx_carrier_err_i
);

  // request matching
  wire std_dev_in = req_type_i == ucs_pkg::RT_STD_DEV_IN;
  wire len_zero   = req_length_i == ucs_pkg::LEN_ZERO;
  wire is_clr_dev = req_type_i == ucs_pkg::RT_STD_DEV_OUT
                  && req_code_i == ucs_pkg::REQ_CLR_FEATURE && len_zero
                  && req_value_i[7:0] == ucs_pkg::FS_REMOTE_WAKE;
  wire ep_ok      = req_index_i[7:0] <= ucs_pkg::EP_NUM_MAX
                  || (req_index_i[7] && req_index_i[6:0] <= 7'h03);
  wire is_clr_ep  = req_type_i == ucs_pkg::RT_STD_EP_OUT
                  && req_code_i == ucs_pkg::REQ_CLR_FEATURE && len_zero
                  && req_value_i[7:0] == ucs_pkg::FS_EP_HALT && ep_ok;
  wire is_cfg     = std_dev_in && req_code_i == ucs_pkg::REQ_GET_CONFIG
                  && req_length_i == ucs_pkg::LEN_ONE;
  wire is_iface   = req_type_i == ucs_pkg::RT_STD_IF_IN
                  && req_code_i == ucs_pkg::REQ_GET_IFACE
                  && req_length_i == ucs_pkg::LEN_ONE
                  && req_index_i == ucs_pkg::LEN_ZERO;
  wire is_dstat   = std_dev_in && req_code_i == ucs_pkg::REQ_GET_STATUS
                  && req_length_i == ucs_pkg::LEN_TWO;
  wire is_estat   = req_type_i == ucs_pkg::RT_STD_EP_IN
                  && req_code_i == ucs_pkg::REQ_GET_STATUS
                  && req_length_i == ucs_pkg::LEN_TWO
                  && (req_index_i[7:0] == ucs_pkg::EP_BULK_IN
                   || req_index_i[7:0] == ucs_pkg::EP_BULK_OUT);
  wire [7:0] dtype = req_value_i[15:8];
  // interface and endpoint types fall out of this list and stall
  wire desc_ok    = dtype == ucs_pkg::DT_DEVICE || dtype == ucs_pkg::DT_CONFIG
                  || dtype == ucs_pkg::DT_STRING
                  || dtype == ucs_pkg::DT_QUALIFIER
                  || dtype == ucs_pkg::DT_OTHER_SPEED;
  wire is_desc    = std_dev_in && req_code_i == ucs_pkg::REQ_GET_DESC
                  && desc_ok;
  wire stat_tx    = req_index_i == ucs_pkg::SEL_TX_STATS;
  wire is_stats   = req_type_i == ucs_pkg::RT_VENDOR_IN
                  && req_code_i == ucs_pkg::REQ_GET_STATS
                  && (stat_tx ? req_length_i == ucs_pkg::LEN_TX_STATS
                              : req_length_i == ucs_pkg::LEN_RX_STATS);
  wire is_short   = is_cfg || is_iface || is_dstat || is_estat;
  // anything else, set descriptor and synch frame included, stalls
  wire unsupported = !(is_clr_dev || is_clr_ep || is_short || is_desc
                     || is_stats);

  // status and one-byte answers
  wire [15:0] short_word =
      is_cfg   ? {8'h00, config_value_i} :
      is_iface ? {8'h00, alt_setting_i} :
      is_dstat ? {14'h0000, remote_wake_i, self_powered_i} :
      {15'h0000, ep_halt_i[req_index_i[1:0]]};

  // counter events for one frame
  logic [ucs_pkg::NUM_CNT-1:0] inc;
  wire rx_keep = rx_done_i && !rx_dropped_i;
  wire rx_crc  = rx_crc_err_i && !rx_dribble_i;
  wire rx_aln  = rx_crc_err_i && rx_dribble_i;
  wire rx_long = rx_length_i > rx_max_len_i;
  wire rx_runt = rx_crc_err_i && rx_length_i < ucs_pkg::RUNT_LEN;
  wire rx_any  = rx_crc_err_i || rx_long || rx_late_col_i || rx_other_err_i;
  wire rx_good = rx_done_i && !rx_any;
  wire tx_abort = tx_excess_col_i || tx_late_col_i || tx_underrun_i
                || tx_excess_defer_i;
  wire tx_ok   = tx_done_i && !tx_abort && !tx_carrier_err_i;
  assign inc[ucs_pkg::RX_GOOD]   = rx_good;
  assign inc[ucs_pkg::RX_CRC]    = rx_keep && rx_crc;
  assign inc[ucs_pkg::RX_RUNT]   = rx_keep && rx_runt;
  assign inc[ucs_pkg::RX_ALIGN]  = rx_keep && rx_aln;
  assign inc[ucs_pkg::RX_LONG]   = rx_keep && rx_long;
  assign inc[ucs_pkg::RX_LATE]   = rx_keep && rx_late_col_i;
  assign inc[ucs_pkg::RX_BAD]    = rx_keep && rx_any;
  assign inc[ucs_pkg::RX_DROP]   = rx_done_i && rx_dropped_i;
  assign inc[ucs_pkg::TX_GOOD]   = tx_ok && !tx_pause_i;
  assign inc[ucs_pkg::TX_PAUSE]  = tx_ok && tx_pause_i;
  assign inc[ucs_pkg::TX_SINGLE] = tx_ok && tx_col_count_i == 4'h1;
  assign inc[ucs_pkg::TX_MULTI]  = tx_ok && tx_col_count_i > 4'h1;
  assign inc[ucs_pkg::TX_EXCOL]  = tx_done_i && tx_excess_col_i;
  assign inc[ucs_pkg::TX_LATE]   = tx_done_i && tx_late_col_i;
  assign inc[ucs_pkg::TX_UNDER]  = tx_done_i && tx_underrun_i;
  assign inc[ucs_pkg::TX_DEFER]  = tx_done_i && tx_excess_defer_i;
  assign inc[ucs_pkg::TX_CARR]   = tx_done_i && tx_carrier_err_i;
  assign inc[ucs_pkg::TX_BAD]    = tx_done_i
                                 && (tx_abort || tx_carrier_err_i);

  // data stage sequencing
  ucs_pkg::ucs_state_e state_r;
  ucs_pkg::ucs_state_e state_nxt;
  logic [5:0]  byte_cnt_r;
  logic [5:0]  last_byte_r;
  logic        src_stats_r;
  logic        src_tx_r;
  logic [15:0] short_r;
  logic [ucs_pkg::CNT_W-1:0] snap_r [ucs_pkg::NUM_CNT];
  logic [ucs_pkg::CNT_W-1:0] cnt_r  [ucs_pkg::NUM_CNT];

  wire take_stats = setup_valid_i && state_r == ucs_pkg::ST_IDLE && is_stats;
  wire take_short = setup_valid_i && state_r == ucs_pkg::ST_IDLE && is_short;
  wire beat       = state_r == ucs_pkg::ST_SEND && in_ready_i;
  wire end_beat   = beat && byte_cnt_r == last_byte_r;
  // older variant clears at the close of the statistics read
  wire clear_rx   = end_beat && src_stats_r && !src_tx_r && !wrap_mode_i;
  wire clear_tx   = end_beat && src_stats_r && src_tx_r && !wrap_mode_i;

  // the counters, one per slot
  genvar g;
  generate
    for (g = 0; g < ucs_pkg::NUM_CNT; g++) begin : g_cnt
      localparam bit SHORT = ucs_pkg::SHORT_MASK[g];
      localparam logic [ucs_pkg::CNT_W-1:0] TOP = SHORT
          ? {{(ucs_pkg::CNT_W-ucs_pkg::SHORT_W){1'b0}},
             {ucs_pkg::SHORT_W{1'b1}}}
          : {ucs_pkg::CNT_W{1'b1}};
      wire clr = (g < ucs_pkg::NUM_RX) ? clear_rx : clear_tx;
      wire at_top = cnt_r[g] == TOP;
      // wrap past the top clears to zero; saturation holds at the top
      wire [ucs_pkg::CNT_W-1:0] bump = at_top
          ? (wrap_mode_i ? '0 : TOP)
          : cnt_r[g] + 32'h0000_0001;
      // a frame finishing at the clearing edge still counts as one
      wire [ucs_pkg::CNT_W-1:0] cnt_nxt = clr
          ? {{(ucs_pkg::CNT_W-1){1'b0}}, inc[g]}
          : (inc[g] ? bump : cnt_r[g]);
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          cnt_r[g]  <= '0;
          snap_r[g] <= '0;
        end else begin
          cnt_r[g] <= cnt_nxt;
          if (take_stats) begin
            snap_r[g] <= cnt_r[g];
          end
        end
      end
    end
  endgenerate

  // byte selection from the snapshot, little endian per word
  wire [4:0] word_idx = {1'b0, byte_cnt_r[5:2]}
                      + (src_tx_r ? 5'(ucs_pkg::NUM_RX) : 5'h00);
  wire [ucs_pkg::CNT_W-1:0] sel_word = snap_r[word_idx];
  wire [7:0] stat_byte = sel_word[8*byte_cnt_r[1:0] +: 8];
  wire [7:0] short_byte = byte_cnt_r[0] ? short_r[15:8] : short_r[7:0];

  // state advance
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ucs_pkg::ST_IDLE: begin
        if (take_stats || take_short) begin
          state_nxt = ucs_pkg::ST_SEND;
        end
      end
      ucs_pkg::ST_SEND: begin
        if (end_beat) begin
          state_nxt = ucs_pkg::ST_DONE;
        end
      end
      default: state_nxt = ucs_pkg::ST_IDLE;
    endcase
  end

  // transfer bookkeeping
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state_r     <= ucs_pkg::ST_IDLE;
      byte_cnt_r  <= '0;
      last_byte_r <= '0;
      src_stats_r <= 1'b0;
      src_tx_r    <= 1'b0;
      short_r     <= '0;
    end else begin
      state_r <= state_nxt;
      if (take_stats || take_short) begin
        byte_cnt_r  <= '0;
        last_byte_r <= 6'(req_length_i[5:0] - 6'h01);
        src_stats_r <= take_stats;
        src_tx_r    <= take_stats && stat_tx;
        short_r     <= short_word;
      end else if (beat) begin
        byte_cnt_r <= byte_cnt_r + 6'h01;
      end
    end
  end

  // one-cycle answers to the setup stage
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      stall_o           <= 1'b0;
      ack_o             <= 1'b0;
      desc_req_o        <= 1'b0;
      desc_type_o       <= 8'h00;
      desc_index_o      <= 8'h00;
      clr_remote_wake_o <= 1'b0;
      clr_ep_halt_o     <= 1'b0;
      clr_ep_num_o      <= 2'h0;
    end else begin
      stall_o <= (setup_valid_i && state_r == ucs_pkg::ST_IDLE
                  && unsupported);
      ack_o   <= state_r == ucs_pkg::ST_DONE
              || (setup_valid_i && state_r == ucs_pkg::ST_IDLE
                  && (is_clr_dev || is_clr_ep));
      desc_req_o        <= setup_valid_i && state_r == ucs_pkg::ST_IDLE
                           && is_desc;
      clr_remote_wake_o <= setup_valid_i && state_r == ucs_pkg::ST_IDLE
                           && is_clr_dev;
      clr_ep_halt_o     <= setup_valid_i && state_r == ucs_pkg::ST_IDLE
                           && is_clr_ep;
      if (setup_valid_i && state_r == ucs_pkg::ST_IDLE) begin
        desc_type_o  <= dtype;
        desc_index_o <= req_value_i[7:0];
        clr_ep_num_o <= req_index_i[1:0];
      end
    end
  end

  // data stage outputs; byte source is registered state
  assign in_valid_o = state_r == ucs_pkg::ST_SEND;
  assign in_data_o  = in_valid_o ? (src_stats_r ? stat_byte : short_byte)
                                 : 8'h00;
  assign in_last_o  = in_valid_o && byte_cnt_r == last_byte_r;

endmodule

// *** ucs_ctrl_assertions.sv ***
// port-level assertions for the control request decoder
`timescale 1ns/1ps
module ucs_ctrl_assertions (
  // clock and reset
  input wire logic        clk_i, reset_i,
  // setup stage
  input wire logic        setup_valid_i,
  input wire logic [7:0]  req_type_i, req_code_i,
  input wire logic [15:0] req_value_i, req_index_i, req_length_i,
  // data stage and answers
  input wire logic        in_ready_i, in_valid_o, in_last_o, stall_o, ack_o,
  input wire logic [7:0]  in_data_o, desc_type_o,
  input wire logic        desc_req_o, clr_remote_wake_o, clr_ep_halt_o,
  input wire logic [1:0]  clr_ep_num_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // a setup taken while idle; ack and the cycle after a stream are excluded
  sequence s_take;
    setup_valid_i && !in_valid_o && !ack_o && !$past(in_valid_o);
  endsequence
  sequence s_std(logic [7:0] t, logic [7:0] c);
    s_take ##0 (req_type_i == t && req_code_i == c);
  endsequence

  chk_dev_status: assert property (
    s_std(8'h80, 8'h00) ##0 (req_length_i == 16'h0002 && req_index_i == 0)
    |=> in_valid_o && in_data_o[7:2] == 6'h00 && !in_last_o)
    else $error("device status byte malformed");
  chk_config_byte: assert property (
    s_std(8'h80, 8'h08) ##0 (req_length_i == 16'h0001 && req_index_i == 0)
    |=> in_valid_o && in_last_o) else $error("configuration not one byte");
  chk_iface_byte: assert property (
    s_std(8'h81, 8'h0a) ##0 (req_length_i == 16'h0001 && req_index_i == 0)
    |=> in_valid_o && in_last_o) else $error("interface not one byte");
  chk_ep_status: assert property (
    s_std(8'h82, 8'h00) ##0 (req_length_i == 2 && req_index_i == 16'h0081)
    |=> in_valid_o && in_data_o[7:1] == 7'h00)
    else $error("endpoint status byte malformed");
  chk_unsup_stall: assert property (
    s_take ##0 (req_code_i == 8'h07 || req_code_i == 8'h0c)
    |=> stall_o && !ack_o) else $error("unsupported request not stalled");
  chk_desc_stall: assert property (
    s_std(8'h80, 8'h06) ##0 (req_value_i[15:8] inside {8'h04, 8'h05})
    |=> stall_o && !desc_req_o) else $error("descriptor not stalled");
  chk_desc_pass: assert property (
    s_std(8'h80, 8'h06) ##0 (req_value_i[15:8] inside {8'h01, 8'h02, 8'h03,
    8'h06, 8'h07}) |=> desc_req_o && desc_type_o == $past(req_value_i[15:8]))
    else $error("descriptor not handed on");
  chk_wake_clear: assert property (
    s_std(8'h00, 8'h01) ##0 (req_value_i == 16'h0001 && req_length_i == 0 &&
    req_index_i == 0) |=> clr_remote_wake_o && ack_o && !clr_ep_halt_o)
    else $error("wakeup clear missing");
  chk_halt_clear: assert property (
    s_std(8'h02, 8'h01) ##0 (req_value_i == 0 && req_length_i == 0 &&
    req_index_i <= 16'h0003) |=> clr_ep_halt_o && ack_o &&
    clr_ep_num_o == $past(req_index_i[1:0])) else $error("halt clear wrong");
  chk_clear_len: assert property (
    s_take ##0 (req_code_i == 8'h01 && !req_type_i[7] && req_length_i != 0)
    |=> stall_o && !ack_o) else $error("clear with data not stalled");
  chk_last_ack: assert property (
    in_valid_o && in_ready_i && in_last_o |=> !in_valid_o ##1 ack_o)
    else $error("no ack after last byte");
  chk_byte_hold: assert property (
    in_valid_o && !in_ready_i |=> in_valid_o && $stable(in_data_o) &&
    $stable(in_last_o)) else $error("byte changed while held");
endmodule

bind ucs_ctrl ucs_ctrl_assertions i_ucs_ctrl_assertions (
  .clk_i(clk_i), .reset_i(reset_i), .setup_valid_i(setup_valid_i),
  .req_type_i(req_type_i), .req_code_i(req_code_i),
  .req_value_i(req_value_i), .req_index_i(req_index_i),
  .req_length_i(req_length_i), .in_ready_i(in_ready_i),
  .in_valid_o(in_valid_o), .in_last_o(in_last_o), .stall_o(stall_o),
  .ack_o(ack_o), .in_data_o(in_data_o), .desc_type_o(desc_type_o),
  .desc_req_o(desc_req_o), .clr_remote_wake_o(clr_remote_wake_o),
  .clr_ep_halt_o(clr_ep_halt_o), .clr_ep_num_o(clr_ep_num_o));

// *** ucs_host.sv ***
// host model: takes data stage bytes promptly or with random holds
`timescale 1ns/1ps
module ucs_host (
  // clock, reset and pacing
  input  wire logic clk_i,
  input  wire logic reset_i,
  input  wire logic slow_i,
  // data stage acceptance
  output logic      in_ready_o
);
  int seed = 32'hb75716ac;
  // a slow host holds off about half the bytes but never leaves a stage
  always_ff @(posedge clk_i)
    if (reset_i)
      in_ready_o <= 1'b0;
    else
      in_ready_o <= !slow_i || $random(seed) & 1;
endmodule

// *** tb.sv ***
// self-checking bench: requests, frame events and a byte scoreboard
`timescale 1ns/1ps
module tb;
  // design ports
  logic        clk_i, reset_i, wrap_mode_i, setup_valid_i, in_ready_i;
  logic [7:0]  req_type_i, req_code_i, config_value_i, alt_setting_i;
  logic [15:0] req_value_i, req_index_i, req_length_i;
  logic        self_powered_i, remote_wake_i, rx_done_i, rx_crc_err_i;
  logic        rx_dribble_i, rx_late_col_i, rx_other_err_i, rx_dropped_i;
  logic [13:0] rx_length_i, rx_max_len_i;
  logic [3:0]  ep_halt_i, tx_col_count_i;
  logic        tx_done_i, tx_pause_i, tx_excess_col_i, tx_late_col_i;
  logic        tx_underrun_i, tx_excess_defer_i, tx_carrier_err_i;
  logic        in_valid_o, in_last_o, stall_o, ack_o, desc_req_o, slow;
  logic        clr_remote_wake_o, clr_ep_halt_o;
  logic [7:0]  in_data_o, desc_type_o, desc_index_o;
  logic [1:0]  clr_ep_num_o;
  // expected bytes {last, data} and counter model
  int          seed, fail_count, comparisons;
  logic [8:0]  q[$];
  logic [31:0] ex[18] = '{default: '0};
  logic [7:0]  dt[7] = '{8'h01, 8'h02, 8'h03, 8'h06, 8'h07, 8'h04, 8'h05};
  logic [31:0] r;

  ucs_ctrl i_ucs_ctrl (.clk_i(clk_i), .reset_i(reset_i),
    .wrap_mode_i(wrap_mode_i), .setup_valid_i(setup_valid_i),
    .req_type_i(req_type_i), .req_code_i(req_code_i),
    .req_value_i(req_value_i), .req_index_i(req_index_i),
    .req_length_i(req_length_i), .in_ready_i(in_ready_i),
    .in_valid_o(in_valid_o), .in_data_o(in_data_o), .in_last_o(in_last_o),
    .stall_o(stall_o), .ack_o(ack_o), .desc_req_o(desc_req_o),
    .desc_type_o(desc_type_o), .desc_index_o(desc_index_o),
    .config_value_i(config_value_i), .alt_setting_i(alt_setting_i),
    .self_powered_i(self_powered_i), .remote_wake_i(remote_wake_i),
    .ep_halt_i(ep_halt_i), .clr_remote_wake_o(clr_remote_wake_o),
    .clr_ep_halt_o(clr_ep_halt_o), .clr_ep_num_o(clr_ep_num_o),
    .rx_done_i(rx_done_i), .rx_crc_err_i(rx_crc_err_i),
    .rx_dribble_i(rx_dribble_i), .rx_length_i(rx_length_i),
    .rx_max_len_i(rx_max_len_i), .rx_late_col_i(rx_late_col_i),
    .rx_other_err_i(rx_other_err_i), .rx_dropped_i(rx_dropped_i),
    .tx_done_i(tx_done_i), .tx_pause_i(tx_pause_i),
    .tx_col_count_i(tx_col_count_i), .tx_excess_col_i(tx_excess_col_i),
    .tx_late_col_i(tx_late_col_i), .tx_underrun_i(tx_underrun_i),
    .tx_excess_defer_i(tx_excess_defer_i),
    .tx_carrier_err_i(tx_carrier_err_i));
  ucs_host i_ucs_host (.clk_i(clk_i), .reset_i(reset_i), .slow_i(slow),
    .in_ready_o(in_ready_i));

  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic chk(input string s, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // queue a little endian value, low byte first
  task automatic put(input logic [31:0] w, input int nb, input logic lst);
    for (int i = 0; i < nb; i++)
      q.push_back({lst && i == nb - 1, w[8*i +: 8]});
  endtask

  // k: 0 data stage, 1 stall, 2 ack, 3 descriptor hand-off
  task automatic req(input logic [7:0] t, c, input logic [15:0] v, x, l,
                     input int k);
    int n;
    @(posedge clk_i);
    setup_valid_i <= 1'b1;
    {req_type_i, req_code_i, req_value_i, req_index_i, req_length_i}
      <= {t, c, v, x, l};
    @(posedge clk_i);
    setup_valid_i <= 1'b0;
    #1;
    chk("stall", k == 1, stall_o);
    chk("ack", k == 2, ack_o);
    chk("desc req", k == 3, desc_req_o);
    if (k == 0) begin
      n = 0;
      while (ack_o !== 1'b1 && n < 400) begin
        @(posedge clk_i);
        #1;
        n++;
      end
      if (n >= 400) begin
        fail_count++;
        tally_and_finish;
      end
      chk("bytes left", 0, q.size());
    end
  endtask

  // back-to-back rx and tx frame events with random status
  task automatic frames(input int n);
    logic c, d, lt, o, dp, ps, xc, tl, un, df, cr, e, b;
    logic [3:0]  col;
    logic [13:0] len;
    logic [17:0] inc;
    for (int f = 0; f < n; f++) begin
      r = $random(seed);
      {c, d, lt, o, dp} = {&r[1:0], r[2], &r[7:5], &r[10:8], &r[12:11]};
      {ps, xc, tl, un} = {&r[18:17], &r[21:19], &r[24:22], &r[27:25]};
      {df, cr} = {&r[30:28], r[31] & r[0]};
      col = r[13] ? {1'b0, r[16:14]} : 4'h0;
      len = r[3] ? 14'h0028 : (r[4] ? 14'h0640 : 14'h01f4);
      @(posedge clk_i);
      {rx_done_i, rx_crc_err_i, rx_dribble_i, rx_late_col_i, rx_other_err_i,
       rx_dropped_i, rx_length_i} <= {1'b1, c, d, lt, o, dp, len};
      {tx_done_i, tx_pause_i, tx_col_count_i, tx_excess_col_i, tx_late_col_i,
       tx_underrun_i, tx_excess_defer_i, tx_carrier_err_i}
        <= {1'b1, ps, col, xc, tl, un, df, cr};
      e = c | (len > rx_max_len_i) | lt | o;
      b = xc | tl | un | df | cr;
      inc[ucs_pkg::RX_GOOD] = !e;
      inc[ucs_pkg::RX_DROP] = dp;
      inc[ucs_pkg::RX_CRC] = !dp & c & !d;
      inc[ucs_pkg::RX_ALIGN] = !dp & c & d;
      inc[ucs_pkg::RX_RUNT] = !dp & c & (len < ucs_pkg::RUNT_LEN);
      inc[ucs_pkg::RX_LONG] = !dp & (len > rx_max_len_i);
      inc[ucs_pkg::RX_LATE] = !dp & lt;
      inc[ucs_pkg::RX_BAD] = !dp & e;
      inc[ucs_pkg::TX_GOOD] = !b & !ps;
      inc[ucs_pkg::TX_PAUSE] = !b & ps;
      inc[ucs_pkg::TX_SINGLE] = !b & (col == 4'h1);
      inc[ucs_pkg::TX_MULTI] = !b & (col > 4'h1);
      inc[17:12] = {b, cr, df, un, tl, xc};
      for (int k = 0; k < 18; k++)
        ex[k] += inc[k];
    end
    @(posedge clk_i);
    {rx_done_i, tx_done_i} <= 2'b00;
  endtask

  // read one statistics block; newer variant sees frames mid-read
  task automatic stats(input logic tx);
    int b, m;
    b = tx ? 8 : 0;
    m = tx ? 10 : 8;
    for (int i = 0; i < m; i++)
      put(ucs_pkg::SHORT_MASK[b+i] ? ex[b+i] & 32'h000fffff : ex[b+i], 4,
          i == m - 1);
    fork
      req(8'hc0, 8'ha2, 0, tx, tx ? 16'h0028 : 16'h0020, 0);
      if (wrap_mode_i) begin
        repeat (3) @(posedge clk_i);
        frames(2);
      end
    join
    if (!wrap_mode_i)
      for (int i = 0; i < m; i++)
        ex[b+i] = '0;
  endtask

  // compare every accepted byte with the oldest note
  always @(posedge clk_i)
    if (in_valid_o === 1'b1 && in_ready_i === 1'b1) begin
      if (q.size() == 0)
        chk("extra byte", 0, 1);
      else
        chk("data byte", q.pop_front(), {in_last_o, in_data_o});
    end

  // main sequence: old variant twice, then newer variant twice
  initial begin
    seed = 32'hb75716ac;
    {slow, wrap_mode_i, setup_valid_i, req_type_i, req_code_i, req_value_i,
     req_index_i, req_length_i, config_value_i, alt_setting_i,
     self_powered_i, remote_wake_i, ep_halt_i} = '0;
    {rx_done_i, rx_crc_err_i, rx_dribble_i, rx_length_i, rx_late_col_i,
     rx_other_err_i, rx_dropped_i, tx_done_i, tx_pause_i, tx_col_count_i,
     tx_excess_col_i, tx_late_col_i, tx_underrun_i, tx_excess_defer_i,
     tx_carrier_err_i} = '0;
    rx_max_len_i = 14'h05ee;
    reset_i = 1'b1;
    repeat (10) @(posedge clk_i);
    reset_i <= 1'b0;
    for (int s = 0; s < 4; s++) begin
      r = $random(seed);
      @(posedge clk_i);
      {wrap_mode_i, slow, remote_wake_i, self_powered_i} <= {s[1:0], r[1:0]};
      {ep_halt_i, alt_setting_i, config_value_i} <= {r[5:2], r[23:8]};
      put(r[1:0], 2, 1); req(8'h80, 8'h00, 0, 0, 2, 0);
      put(r[15:8], 1, 1); req(8'h80, 8'h08, 0, 0, 1, 0);
      put(r[23:16], 1, 1); req(8'h81, 8'h0a, 0, 0, 1, 0);
      put(r[3], 2, 1); req(8'h82, 8'h00, 0, 16'h0081, 2, 0);
      put(r[4], 2, 1); req(8'h82, 8'h00, 0, 16'h0002, 2, 0);
      req(8'h00, 8'h01, 16'h0001, 0, 0, 2);
      chk("wake clear", 1, clr_remote_wake_o);
      req(8'h02, 8'h01, 0, r[25:24], 0, 2);
      chk("ep halt", {1'b1, r[25:24]}, {clr_ep_halt_o, clr_ep_num_o});
      req(8'h00, 8'h01, 16'h0001, 0, 1, 1);
      for (int i = 0; i < 7; i++) begin
        req(8'h80, 8'h06, {dt[i], i[7:0]}, 0, 18, i < 5 ? 3 : 1);
        if (i < 5)
          chk("desc", {dt[i], i[7:0]}, {desc_type_o, desc_index_o});
      end
      req(8'h00, 8'h07, 16'h0100, 0, 18, 1);
      req(8'h82, 8'h0c, 0, 16'h0081, 2, 1);
      req(8'hc0, 8'ha2, 0, 0, 16'h0010, 1);
      frames(40);
      stats(0);
      stats(1);
      stats(0);
      stats(1);
      $display("test pass %0d done", s);
    end
    tally_and_finish;
  end
endmodule
